// >>> design/gpio_regs.svh
// Purpose: offsets, field positions, reset values for the line output/interrupt block
// Assumes: registers are 32-bit words at byte offsets in configuration space
// Notes:   definitions only
`ifndef GPIO_REGS_SVH
`define GPIO_REGS_SVH

// register offsets
`define OFS_UPPER_LINE_OUTPUT_LATCH 12'h648
`define OFS_LINE_INTERRUPT_POLARITY 12'h64c
`define OFS_LINE_INTERRUPT_STATUS   12'h650
`define OFS_LINE_INTERRUPT_MASK     12'h654

// reset values
`define RST_UPPER_LINE_OUTPUT_LATCH 16'h0000
`define RST_LINE_INTERRUPT_POLARITY 32'h00000000
`define RST_LINE_INTERRUPT_STATUS   32'h55555554
`define RST_LINE_INTERRUPT_MASK     32'h00000000

// field layout
`define LINE_COUNT                  32
`define HALF_LINES                  16
`define UPPER_LATCH_MSB             15
`define UPPER_LINE_BASE             16

`endif

// >>> design/gpio_pkg.sv
// Purpose: shared types for the line output/interrupt block
// Assumes: 12-bit configuration offsets, 32-bit data
// Notes:   constants live in gpio_regs.svh
package gpio_pkg;

  typedef logic [11:0] reg_addr_t;
  typedef logic [31:0] word_t;
  typedef logic [15:0] half_t;

  // one register access request, at most one of wr / rd per cycle
  typedef struct packed {
    reg_addr_t addr;
    logic      wr;
    logic      rd;
    word_t     wdata;
  } reg_req_s;

  // pin group: level driven and enable per line
  typedef struct packed {
    word_t level;
    word_t enable;
  } pin_drive_s;

endpackage : gpio_pkg

// >>> design/line_status.sv
// Purpose: per-line interrupt status with programmable polarity
// Assumes: pin levels synchronous to clock
// Notes:   status is computed, never loaded by software
`timescale 1ns/1ps
`include "gpio_regs.svh"
`default_nettype none
module line_status
  import gpio_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  nrst,
  input  wire word_t pin_level,
  input  wire word_t polarity,
  output logic       any_active_unused_guard,
  output word_t      status
);

  word_t next_status;

  // active when the level equals the selected polarity: 0 = active low, 1 = active high
  always_comb begin
    next_status = ~(pin_level ^ polarity);
  end

  // reset value reflects the default line state until the first sample
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      status <= `RST_LINE_INTERRUPT_STATUS;
    end else begin
      status <= next_status;
    end
  end

  // spare reduction for the parent, kept so the port is always driven
  assign any_active_unused_guard = |status;

endmodule : line_status
`default_nettype wire

// >>> design/gpio_output_and_interrupt.sv
// Purpose: upper-half output latch, pin drive for all lines, line interrupt logic
// Assumes: one clock, synchronous pins, simple configuration register port
// Notes:   direction words and the lower-half output word come from elsewhere
`timescale 1ns/1ps
`include "gpio_regs.svh"
`default_nettype none
module gpio_output_and_interrupt
  import gpio_pkg::*;
(
  input  wire logic     clock,
  input  wire logic     nrst,
  input  wire reg_req_s reg_req,
  output word_t         reg_rdata,
  input  wire word_t    dir_lower_word,
  input  wire word_t    dir_upper_word,
  input  wire half_t    lower_output_word,
  input  wire word_t    pin_in,
  output word_t         pin_out,
  output word_t         pin_oe,
  output half_t         input_data_lower,
  output half_t         input_data_upper,
  output logic          irq_request
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // direction words hold one enable per line at the odd bit positions
  function automatic half_t odd_bits(input word_t word);
    half_t res;
    res = 16'h0000;
    for (int k = 0; k < `HALF_LINES; k++) begin
      res[k] = word[2 * k + 1];
    end
    return res;
  endfunction : odd_bits

  // decode of one register offset against a write or read request
  function automatic logic hit(input reg_addr_t addr, input reg_addr_t ofs);
    return addr == ofs;
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////////
  // software-written registers

  half_t upper_latch;
  word_t polarity;
  word_t mask;
  half_t next_upper_latch;
  word_t next_polarity;
  word_t next_mask;

  // writes land at the end of the request cycle; status is not writable
  always_comb begin
    next_upper_latch = upper_latch;
    next_polarity    = polarity;
    next_mask        = mask;
    if (reg_req.wr) begin
      if (hit(reg_req.addr, `OFS_UPPER_LINE_OUTPUT_LATCH)) begin
        next_upper_latch = reg_req.wdata[`UPPER_LATCH_MSB:0];
      end
      if (hit(reg_req.addr, `OFS_LINE_INTERRUPT_POLARITY)) begin
        next_polarity = reg_req.wdata;
      end
      if (hit(reg_req.addr, `OFS_LINE_INTERRUPT_MASK)) begin
        next_mask = reg_req.wdata;
      end
    end
  end

  // reserved upper latch bits are not stored, so they preserve zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      upper_latch <= `RST_UPPER_LINE_OUTPUT_LATCH;
      polarity    <= `RST_LINE_INTERRUPT_POLARITY;
      mask        <= `RST_LINE_INTERRUPT_MASK;
    end else begin
      upper_latch <= next_upper_latch;
      polarity    <= next_polarity;
      mask        <= next_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin drive

  half_t dir_lower;
  half_t dir_upper;
  word_t next_pin_out;
  word_t next_pin_oe;

  assign dir_lower = odd_bits(dir_lower_word);
  assign dir_upper = odd_bits(dir_upper_word);

  // a stored bit has no effect on a pin configured as input
  always_comb begin
    next_pin_oe  = {dir_upper, dir_lower};
    next_pin_out = {upper_latch & dir_upper, lower_output_word & dir_lower};
  end

  // registered so the pins change cleanly one cycle after a write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_out <= 32'h00000000;
      pin_oe  <= 32'h00000000;
    end else begin
      pin_out <= next_pin_out;
      pin_oe  <= next_pin_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // input data view

  half_t next_in_lower;
  half_t next_in_upper;

  // output lines read zero; input lines read the sampled pin
  always_comb begin
    next_in_lower = pin_in[`HALF_LINES-1:0] & ~dir_lower;
    next_in_upper = pin_in[`LINE_COUNT-1:`UPPER_LINE_BASE] & ~dir_upper;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      input_data_lower <= 16'h0000;
      input_data_upper <= 16'h0000;
    end else begin
      input_data_lower <= next_in_lower;
      input_data_upper <= next_in_upper;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status and request

  word_t status;

  // status watches every line whatever its direction, so outputs can loop back
  line_status u_line_status (
    .clock                   (clock),
    .nrst                    (nrst),
    .pin_level               (pin_in),
    .polarity                (polarity),
    .any_active_unused_guard (),
    .status                  (status)
  );

  logic next_irq;

  // one combined request, registered to keep the output glitch free
  always_comb begin
    next_irq = |(status & ~mask);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register read

  word_t next_rdata;

  // read data appears one cycle after rd; unmapped offsets read zero
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_req.rd) begin
      unique case (1'b1)
        hit(reg_req.addr, `OFS_UPPER_LINE_OUTPUT_LATCH): next_rdata = {16'h0000, upper_latch};
        hit(reg_req.addr, `OFS_LINE_INTERRUPT_POLARITY): next_rdata = polarity;
        hit(reg_req.addr, `OFS_LINE_INTERRUPT_STATUS):   next_rdata = status;
        hit(reg_req.addr, `OFS_LINE_INTERRUPT_MASK):     next_rdata = mask;
        default:                                         next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule : gpio_output_and_interrupt
`default_nettype wire

// >>> verification/gpio_line_monitor.sv
// Purpose: port-level checks of the line output/interrupt block
// Assumes: shadows of polarity and mask follow register writes
// Notes:   bound to the top module
`timescale 1ns/1ps
`include "gpio_regs.svh"
`default_nettype none
module gpio_line_monitor
  import gpio_pkg::*;
(
  input wire logic     clock,
  input wire logic     nrst,
  input wire reg_req_s reg_req,
  input wire word_t    reg_rdata,
  input wire word_t    dir_lower_word,
  input wire word_t    dir_upper_word,
  input wire half_t    lower_output_word,
  input wire word_t    pin_in,
  input wire word_t    pin_out,
  input wire word_t    pin_oe,
  input wire half_t    input_data_lower,
  input wire half_t    input_data_upper,
  input wire logic     irq_request
);
  word_t odd, pol, msk, st;
  half_t lat;
  ////////////////////////////////////////////////////////////////////////////////
  // expected enable per line from the odd direction bits
  always_comb begin
    for (int k = 0; k < 16; k++) begin
      odd[k] = dir_lower_word[2*k+1];
      odd[16+k] = dir_upper_word[2*k+1];
    end
  end
  // shadows; status is a level, so it is rebuilt every edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pol <= 32'h0;
      msk <= 32'h0;
      st <= 32'h55555554;
      lat <= 16'h0;
    end else begin
      st <= ~(pin_in ^ pol);
      if (reg_req.wr && reg_req.addr == `OFS_UPPER_LINE_OUTPUT_LATCH) lat <= reg_req.wdata[15:0];
      if (reg_req.wr && reg_req.addr == `OFS_LINE_INTERRUPT_POLARITY) pol <= reg_req.wdata;
      if (reg_req.wr && reg_req.addr == `OFS_LINE_INTERRUPT_MASK) msk <= reg_req.wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_oe_from_dir: assert property (
    $past(nrst) |-> pin_oe == $past(odd)) else $error("pin enable mismatch");
  a_out_lower: assert property (
    $past(nrst) |-> pin_out[15:0] == $past(lower_output_word & odd[15:0])) else $error("lower drive mismatch");
  a_out_upper: assert property (
    $past(nrst) |-> pin_out[31:16] == $past(lat & odd[31:16])) else $error("upper drive mismatch");
  a_undriven_low: assert property (
    (pin_out & ~pin_oe) == 32'h0) else $error("undriven line carries data");
  a_input_zero: assert property (
    $past(nrst, 2) && $past(odd) == $past(odd, 2) |-> {input_data_upper, input_data_lower} == $past(pin_in & ~odd))
    else $error("input data mismatch");
  a_status_read: assert property (
    reg_req.rd && reg_req.addr == `OFS_LINE_INTERRUPT_STATUS |=> reg_rdata == $past(st)) else $error("status read");
  a_irq_level: assert property (
    $past(nrst) |-> irq_request == $past(|(st & ~msk))) else $error("request level mismatch");
  a_pol_read: assert property (
    reg_req.rd && reg_req.addr == `OFS_LINE_INTERRUPT_POLARITY |=> reg_rdata == $past(pol)) else $error("polarity read");
  a_mask_read: assert property (
    reg_req.rd && reg_req.addr == `OFS_LINE_INTERRUPT_MASK |=> reg_rdata == $past(msk)) else $error("mask read");
  a_latch_high: assert property (
    reg_req.rd && reg_req.addr == `OFS_UPPER_LINE_OUTPUT_LATCH |=> reg_rdata[31:16] == 16'h0) else $error("latch top");
endmodule : gpio_line_monitor
bind gpio_output_and_interrupt gpio_line_monitor i_gpio_line_monitor (.clock(clock), .nrst(nrst), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .dir_lower_word(dir_lower_word), .dir_upper_word(dir_upper_word),
  .lower_output_word(lower_output_word), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .input_data_lower(input_data_lower), .input_data_upper(input_data_upper), .irq_request(irq_request));
`default_nettype wire

// >>> verification/gpio_line_pads.sv
// Purpose: far-side devices on the general-purpose lines
// Assumes: far side drives every line the device leaves undriven
// Notes:   no contention modelled
`timescale 1ns/1ps
`default_nettype none
module gpio_line_pads
  import gpio_pkg::*;
(
  input  wire word_t pin_out,
  input  wire word_t pin_oe,
  input  wire word_t ext_level,
  output word_t      pin_in
);
  // a driven line shows the device level, the rest the far-side level
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : gpio_line_pads
`default_nettype wire

// >>> verification/tb_gpio_output_and_interrupt.sv
// Purpose: self-checking bench for the line output/interrupt block
// Assumes: requests change at the falling edge
// Notes:   read data checked from a queue of expected words
`timescale 1ns/1ps
`include "gpio_regs.svh"
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin errors++; $display("Error %0t: got %h exp %h", $time, got, exp); end end
module tb_gpio_output_and_interrupt
  import gpio_pkg::*;
;
  logic     clock, nrst, irq, pend;
  reg_req_s req;
  word_t    rdata, dlo, dhi, pout, poe, pin, ext, p, s, l, oe, e;
  half_t    lo_out, idl, idu;
  int       errors, n_checks, cyc, seed;
  word_t    q[$];
  gpio_output_and_interrupt i_gpio_output_and_interrupt (.clock(clock), .nrst(nrst), .reg_req(req), .reg_rdata(rdata),
    .dir_lower_word(dlo), .dir_upper_word(dhi), .lower_output_word(lo_out), .pin_in(pin), .pin_out(pout),
    .pin_oe(poe), .input_data_lower(idl), .input_data_upper(idu), .irq_request(irq));
  gpio_line_pads i_gpio_line_pads (.pin_out(pout), .pin_oe(poe), .ext_level(ext), .pin_in(pin));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic word_t odd_bits(word_t lo, word_t hi);
    word_t r;
    for (int k = 0; k < 16; k++) begin
      r[k] = lo[2*k+1];
      r[16+k] = hi[2*k+1];
    end
    return r;
  endfunction : odd_bits
  task automatic acc(reg_addr_t a, logic w, word_t d);
    @(negedge clock);
    req = {a, w, !w, d};
  endtask : acc
  task automatic rd(reg_addr_t a, word_t x);
    acc(a, 1'b0, 32'h0);
    q.push_back(x);
  endtask : rd
  task automatic idle(int n);
    repeat (n) begin
      @(negedge clock);
      req = '0;
    end
  endtask : idle
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////////
  initial clock = 1'b0;
  always #10 clock = ~clock;
  // a hang counts as a mismatch
  always @(posedge clock) begin
    pend <= req.rd;
    cyc++;
    if (cyc == 2000) begin
      errors++;
      end_sim();
    end
  end
  // read data lands one edge after the request
  always @(negedge clock) begin
    if (pend) begin
      e = q.pop_front();
      `CHK(rdata, e)
    end
  end
  initial begin
    seed = 32'hfe6f04ec;
    {nrst, req, dlo, dhi, lo_out} = '0;
    ext = $random(seed);
    repeat (16) @(negedge clock);
    nrst = 1'b1;
    req = {`OFS_LINE_INTERRUPT_STATUS, 2'b01, 32'h0};
    q.push_back(32'h55555554);
    rd(`OFS_LINE_INTERRUPT_POLARITY, 32'h0);
    rd(`OFS_LINE_INTERRUPT_MASK, 32'h0);
    rd(12'h700, 32'h0);
    // all-high, all-inactive and random polarity; status writes must not stick
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 32'hffffffff : (i == 1) ? ~ext : $random(seed);
      s = ~(ext ^ p);
      acc(`OFS_LINE_INTERRUPT_POLARITY, 1'b1, p);
      acc(`OFS_LINE_INTERRUPT_STATUS, 1'b1, p);
      rd(`OFS_LINE_INTERRUPT_STATUS, s);
      acc(`OFS_LINE_INTERRUPT_MASK, 1'b1, s);
      idle(3);
      `CHK(irq, 1'b0)
      rd(`OFS_LINE_INTERRUPT_MASK, s);
      acc(`OFS_LINE_INTERRUPT_MASK, 1'b1, 32'h0);
      idle(3);
      `CHK(irq, |s)
    end
    // pin drive and input masking over random direction words
    for (int i = 0; i < 8; i++) begin
      l = $random(seed);
      acc(`OFS_UPPER_LINE_OUTPUT_LATCH, 1'b1, l);
      dlo = $random(seed);
      dhi = (i == 0) ? 32'haaaaaaaa : $random(seed);
      lo_out = $random(seed);
      ext = $random(seed);
      rd(`OFS_UPPER_LINE_OUTPUT_LATCH, {16'h0, l[15:0]});
      idle(2);
      oe = odd_bits(dlo, dhi);
      `CHK(poe, oe)
      `CHK(pout, {l[15:0], lo_out} & oe)
      `CHK({idu, idl}, ext & ~oe)
    end
    idle(2);
    end_sim();
  end
endmodule : tb_gpio_output_and_interrupt
`default_nettype wire
